/* File: design/sar_adc_consts.vh */
// Constants and field layouts for the successive-approximation converter sequencer
// Contract
// - Convert sampled input to ten-bit code by successive approximation into result registers.
// - Channel select field picks the input routed to the single sample-and-hold.
// - Reference select picks supply or external pin; negative reference is ground.
// - Clock select: 000 /2, 100 /4, 001 /8, 101 /16, 010 /32, 110 /64, x11 RC.
// - One bit period per conversion clock; full conversion takes eleven bit periods.
// - Divided clocks follow the system clock; RC source runs independently.
// - Completion flag sets at every conversion end regardless of interrupt enable.
// - Hardware never clears the completion flag; software clears it.
// - Interrupt request when completion flag and its enable are both set, even asleep.
// - Conversion interrupt during sleep wakes the device.
// - Justify select stores the result left or right justified.
// - Converter runs only while enabled; writing go starts a conversion.
// - On completion: clear go, set flag, load new result.
// - Clearing go early stops conversion; result keeps previous value.
// - After abort, hold off two bit periods, then restart acquisition automatically.
// - Reset restores registers, turns converter off, ends any conversion.
// - With RC clock, start is delayed one extra instruction cycle after go.
// - With system clock, sleep aborts conversion and powers off, enable stays set.
// - Left justified: high holds bits nine to two, low top bits one and zero.
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH

`define RESULT_BITS_W      10
`define CHAN_SEL_W         4
`define CLK_SEL_W          3
`define CONV_BIT_PERIODS   4'd11
`define ABORT_HOLD_PERIODS 2'd2
`define INSTR_CYCLE_CLKS   3'd4
`define RESULT_RST         8'h00
`define CLK_SEL_RC_LO      2'b11
`define JUSTIFY_LEFT       1'b0

`endif

/* File: design/conv_clock_gen.v */
// Conversion clock tick generator: system divider or registered RC tick
`timescale 1ns/1ps
module conv_clock_gen #(
    parameter DIV_W = 6
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Control
    input  wire       restart,
    input  wire [2:0] clk_sel,
    input  wire       rc_tick,
    // Bit-period tick
    output reg        tick
);
`include "sar_adc_consts.vh"

    reg  [DIV_W-1:0] div_reg;
    reg  [DIV_W-1:0] limit;

    // Divide ratio from select code, bit 2 doubles each step
    always @* begin
        case (clk_sel[1:0])
            2'b00:   limit = clk_sel[2] ? 6'd3  : 6'd1;
            2'b01:   limit = clk_sel[2] ? 6'd15 : 6'd7;
            2'b10:   limit = clk_sel[2] ? 6'd63 : 6'd31;
            default: limit = 6'd0;
        endcase
    end

    // Divider follows clk so period tracks system frequency
    always @(posedge clk) begin
        if (rst || restart) begin
            div_reg <= {DIV_W{1'b0}};
            tick    <= 1'b0;
        end else if (clk_sel[1:0] == `CLK_SEL_RC_LO) begin
            div_reg <= {DIV_W{1'b0}};
            tick    <= rc_tick;             // RC ticks are independent
        end else if (div_reg == limit) begin
            div_reg <= {DIV_W{1'b0}};
            tick    <= 1'b1;
        end else begin
            div_reg <= div_reg + 6'd1;
            tick    <= 1'b0;
        end
    end
endmodule // conv_clock_gen

/* File: design/sar_step.v */
// Successive-approximation register: one trial bit per bit period
`timescale 1ns/1ps
module sar_step #(
    parameter W = 10
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst,
    // Control
    input  wire         load,
    input  wire         step,
    input  wire         comp_in,
    // Trial code to the DAC and state
    output reg  [W-1:0] code,
    output reg  [W-1:0] trial_bit
);

    // Keep bit when comparator says input above trial, then try next
    always @(posedge clk) begin
        if (rst) begin
            code      <= {W{1'b0}};
            trial_bit <= {W{1'b0}};
        end else if (load) begin
            code      <= {1'b1, {(W-1){1'b0}}};
            trial_bit <= {1'b1, {(W-1){1'b0}}};
        end else if (step && (trial_bit != {W{1'b0}})) begin
            code      <= (comp_in ? code : (code & ~trial_bit)) | (trial_bit >> 1);
            trial_bit <= trial_bit >> 1;
        end
    end
endmodule // sar_step

/* File: design/sar_adc_sequencer.v */
// Sequencer for a ten-bit successive-approximation converter
`timescale 1ns/1ps
module sar_adc_sequencer (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Configuration written by software
    input  wire       converter_enable,
    input  wire       go_set,
    input  wire       go_clear,
    input  wire       result_justify_sel,
    input  wire       pos_ref_sel,
    input  wire [3:0] input_channel_sel,
    input  wire [2:0] conv_clock_sel,
    input  wire       conv_complete_irq_en,
    input  wire       flag_clear,
    // Device state
    input  wire       sleep_active,
    // Analog side
    input  wire       rc_osc_tick,
    input  wire       comparator_out,
    // Analog controls
    output reg  [3:0] mux_channel,
    output reg        ref_pin_sel,
    output reg        sample_closed,
    output reg  [9:0] dac_code,
    output reg        analog_on,
    // Status to software
    output reg        go_busy,
    output reg        conv_complete_flag,
    output reg        conv_irq,
    output reg        wake_req,
    output reg  [7:0] result_high,
    output reg  [7:0] result_low
);
`include "sar_adc_consts.vh"

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [4:0] ST_IDLE  = 5'b00001;
    localparam [4:0] ST_DELAY = 5'b00010;
    localparam [4:0] ST_CONV  = 5'b00100;
    localparam [4:0] ST_HOLD  = 5'b01000;
    localparam [4:0] ST_SLEEP = 5'b10000;

    reg  [4:0] state_reg;
    reg  [3:0] period_reg;
    reg  [2:0] instr_reg;
    reg        div_restart;
    wire       tick;
    wire [9:0] sar_code;
    wire [9:0] sar_trial;
    wire       rc_sel;
    wire       abort_req;
    wire       start_req;
    wire       last_period;
    wire       conv_tick;
    wire [9:0] final_code;

    assign rc_sel      = (conv_clock_sel[1:0] == `CLK_SEL_RC_LO);
    // Go is honoured only while the converter is enabled
    assign start_req   = go_set && converter_enable;
    // Disable or go cleared by software ends a running conversion
    assign abort_req   = go_clear || !converter_enable;
    assign last_period = (period_reg == `CONV_BIT_PERIODS - 4'd1);
    // A tick beside the restart pulse is stale from the free-running divider
    assign conv_tick   = tick && !div_restart;
    // Last trial is decided at the final tick, so bit zero is settled
    assign final_code  = comparator_out ? sar_code : (sar_code & ~sar_trial);

    // ------------------------------------------------------------
    // Clock and SAR datapath
    // ------------------------------------------------------------
    conv_clock_gen #(
        .DIV_W (6)
    ) u_clk (
        .clk     (clk),
        .rst     (rst),
        .restart (div_restart),
        .clk_sel (conv_clock_sel),
        .rc_tick (rc_osc_tick),
        .tick    (tick)
    );

    sar_step #(
        .W (`RESULT_BITS_W)
    ) u_sar (
        .clk       (clk),
        .rst       (rst),
        .load      (div_restart),
        .step      (conv_tick && (state_reg == ST_CONV) && (period_reg != 4'd0)),
        .comp_in   (comparator_out),
        .code      (sar_code),
        .trial_bit (sar_trial)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Divider restart pulse lines up with conversion start
    always @(posedge clk) begin
        if (rst) begin
            div_restart <= 1'b0;
        end else begin
            div_restart <= ((state_reg == ST_IDLE) && start_req && !rc_sel) ||
                           ((state_reg == ST_DELAY) && (instr_reg == 3'd1));
        end
    end

    // Main sequence: idle, optional RC delay, eleven periods, abort hold
    always @(posedge clk) begin
        if (rst) begin
            state_reg  <= ST_IDLE;
            period_reg <= 4'd0;
            instr_reg  <= 3'd0;
            go_busy    <= 1'b0;
            result_high <= `RESULT_RST;
            result_low  <= `RESULT_RST;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    period_reg <= 4'd0;
                    if (sleep_active && !rc_sel && converter_enable) begin
                        state_reg <= ST_SLEEP;
                    end else if (start_req) begin
                        go_busy <= 1'b1;
                        if (rc_sel) begin
                            // Extra instruction cycle lets sleep execute
                            instr_reg <= `INSTR_CYCLE_CLKS;
                            state_reg <= ST_DELAY;
                        end else begin
                            state_reg <= ST_CONV;
                        end
                    end
                end
                ST_DELAY: begin
                    if (abort_req) begin
                        go_busy   <= 1'b0;
                        state_reg <= ST_HOLD;
                    end else if (instr_reg == 3'd1) begin
                        state_reg <= ST_CONV;
                    end else begin
                        instr_reg <= instr_reg - 3'd1;
                    end
                end
                ST_CONV: begin
                    if (abort_req || (sleep_active && !rc_sel)) begin
                        // Result left untouched on abort
                        go_busy    <= 1'b0;
                        period_reg <= 4'd0;
                        state_reg  <= (sleep_active && !rc_sel) ? ST_SLEEP : ST_HOLD;
                    end else if (conv_tick) begin
                        if (last_period) begin
                            // Eleven bit periods done
                            go_busy   <= 1'b0;
                            state_reg <= ST_IDLE;
                            if (result_justify_sel == `JUSTIFY_LEFT) begin
                                result_high <= final_code[9:2];
                                result_low  <= {final_code[1:0], 6'h00};
                            end else begin
                                result_high <= {6'h00, final_code[9:8]};
                                result_low  <= final_code[7:0];
                            end
                        end else begin
                            period_reg <= period_reg + 4'd1;
                        end
                    end
                end
                ST_HOLD: begin
                    // Two bit periods before acquisition resumes
                    if (tick) begin
                        if (period_reg == {2'b00, `ABORT_HOLD_PERIODS} - 4'd1) begin
                            period_reg <= 4'd0;
                            state_reg  <= ST_IDLE;
                        end else begin
                            period_reg <= period_reg + 4'd1;
                        end
                    end
                end
                ST_SLEEP: begin
                    // Powered down but enable left set until wake
                    go_busy <= 1'b0;
                    if (!sleep_active || !converter_enable) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Completion flag, interrupt and wake
    // ------------------------------------------------------------
    // Set wins over a software clear in the same cycle
    always @(posedge clk) begin
        if (rst) begin
            conv_complete_flag <= 1'b0;
        end else if ((state_reg == ST_CONV) && conv_tick && last_period && !abort_req &&
                     !(sleep_active && !rc_sel)) begin
            conv_complete_flag <= 1'b1;
        end else if (flag_clear) begin
            conv_complete_flag <= 1'b0;
        end
    end

    // Request follows flag and enable, awake or asleep
    always @(posedge clk) begin
        if (rst) begin
            conv_irq <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            conv_irq <= conv_complete_flag && conv_complete_irq_en;
            wake_req <= conv_complete_flag && conv_complete_irq_en && sleep_active;
        end
    end

    // ------------------------------------------------------------
    // Analog controls
    // ------------------------------------------------------------
    // Mux and reference follow software; sample closed while acquiring
    always @(posedge clk) begin
        if (rst) begin
            mux_channel   <= 4'h0;
            ref_pin_sel   <= 1'b0;
            sample_closed <= 1'b0;
            dac_code      <= 10'h000;
            analog_on     <= 1'b0;
        end else begin
            mux_channel   <= input_channel_sel;
            ref_pin_sel   <= pos_ref_sel;
            analog_on     <= converter_enable && (state_reg != ST_SLEEP);
            sample_closed <= converter_enable && ((state_reg == ST_IDLE) ||
                             (state_reg == ST_DELAY));
            dac_code      <= sar_code;
        end
    end

endmodule // sar_adc_sequencer

/* File: verification/sar_adc_monitor.sv */
// Port-level checker for the converter sequencer
`timescale 1ns/1ps
module sar_adc_monitor (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Software controls
    input wire logic       converter_enable,
    input wire logic       go_clear,
    input wire logic       result_justify_sel,
    input wire logic       pos_ref_sel,
    input wire logic [3:0] input_channel_sel,
    input wire logic [2:0] conv_clock_sel,
    input wire logic       conv_complete_irq_en,
    input wire logic       flag_clear,
    input wire logic       sleep_active,
    // Observed outputs
    input wire logic [3:0] mux_channel,
    input wire logic       ref_pin_sel,
    input wire logic       analog_on,
    input wire logic       go_busy,
    input wire logic       conv_complete_flag,
    input wire logic       conv_irq,
    input wire logic [7:0] result_high,
    input wire logic [7:0] result_low
);
    // ----------------------------------------
    // Common clocking and helpers
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire [15:0] res = {result_high, result_low};

    // Completion: go drops and the flag is up in the same cycle
    sequence s_done;
        $fell(go_busy) ##0 conv_complete_flag;
    endsequence
    // Quiet idle with steady channel choice
    sequence s_idle_steady;
        (converter_enable && !go_busy && !sleep_active && $stable(input_channel_sel))[*3];
    endsequence

    chk_flag_sticky: assert property (conv_complete_flag && !flag_clear |=> conv_complete_flag)
        else $error("completion flag dropped without clear");
    chk_result_cause: assert property ($changed(res) |-> s_done)
        else $error("result changed outside completion");
    chk_flag_rise: assert property ($rose(conv_complete_flag) |-> $fell(go_busy))
        else $error("flag set without end of conversion");
    chk_irq_follow: assert property (1 |=> conv_irq == $past(conv_complete_flag && conv_complete_irq_en))
        else $error("interrupt request not flag and enable");
    chk_no_start_off: assert property (!converter_enable && !go_busy |=> !go_busy)
        else $error("conversion started while disabled");
    chk_abort_stops: assert property (go_busy && go_clear |=> !go_busy && $stable(res))
        else $error("abort did not stop or touched result");
    chk_sleep_off: assert property (sleep_active && go_busy && conv_clock_sel[1:0] != 2'b11
        |-> ##[1:2] (!go_busy && !analog_on))
        else $error("sleep did not abort system clocked conversion");
    chk_ref_follow: assert property ((converter_enable && !sleep_active && $stable(pos_ref_sel))[*3]
        |-> ref_pin_sel == pos_ref_sel)
        else $error("reference select not followed");
    chk_mux_follow: assert property (s_idle_steady |-> mux_channel == input_channel_sel)
        else $error("channel select not followed");
    chk_pad_zero: assert property ($changed(res) |-> (result_justify_sel ? result_high[7:2] == 6'h00
        : result_low[5:0] == 6'h00))
        else $error("unused result bits not zero");
    chk_busy_span: assert property ($rose(go_busy) && conv_clock_sel == 3'b000
        |-> go_busy[*8] ##[12:30] !go_busy)
        else $error("fastest conversion length off");
endmodule // sar_adc_monitor

bind sar_adc_sequencer sar_adc_monitor mon (.clk, .rst, .converter_enable, .go_clear,
    .result_justify_sel, .pos_ref_sel, .input_channel_sel, .conv_clock_sel, .conv_complete_irq_en,
    .flag_clear, .sleep_active, .mux_channel, .ref_pin_sel, .analog_on, .go_busy,
    .conv_complete_flag, .conv_irq, .result_high, .result_low);

/* File: verification/analog_front.sv */
// Behavioural model of the analog inputs, comparator and RC oscillator
`timescale 1ns/1ps
module analog_front #(
    parameter RC_DIV = 7
) (
    // Clock
    input  wire logic       clk,
    // Controls from the sequencer
    input  wire logic [3:0] mux_channel,
    input  wire logic       ref_pin_sel,
    input  wire logic       sample_closed,
    input  wire logic [9:0] dac_code,
    input  wire logic       analog_on,
    // Answers
    output logic            comparator_out,
    output logic            rc_osc_tick
);
    logic [9:0] held_reg   = 10'h000;
    logic [3:0] rc_cnt_reg = 4'h0;
    logic       junk_reg   = 1'b0;

    // Track while the switch is closed; level depends on channel and reference
    always @(posedge clk) begin
        if (sample_closed)
            held_reg <= {mux_channel, 6'h2b} ^ {10{ref_pin_sel}};
        junk_reg <= ~junk_reg;
        rc_cnt_reg <= (rc_cnt_reg == RC_DIV - 1) ? 4'h0 : rc_cnt_reg + 4'h1;
    end

    // Powered down comparator toggles, so nothing may lean on it
    assign comparator_out = analog_on ? (held_reg >= dac_code) : junk_reg;
    // Free running oscillator, unrelated to any start
    assign rc_osc_tick = (rc_cnt_reg == 4'h0);
endmodule // analog_front

/* File: verification/sar_adc_sequencer_bench.sv */
// Self-checking testbench for the converter sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_bench;
    logic       clk = 0, rst = 1, converter_enable = 0, go_set = 0, go_clear = 0;
    logic       result_justify_sel = 0, pos_ref_sel = 0, conv_complete_irq_en = 0;
    logic       flag_clear = 0, sleep_active = 0;
    logic [3:0] input_channel_sel = 4'h0;
    logic [2:0] conv_clock_sel = 3'h0;
    wire        rc_osc_tick, comparator_out, ref_pin_sel, sample_closed, analog_on;
    wire        go_busy, conv_complete_flag, conv_irq, wake_req;
    wire  [3:0] mux_channel;
    wire  [9:0] dac_code;
    wire  [7:0] result_high, result_low;
    int         errors = 0, checked = 0;

    sar_adc_sequencer dut (.clk, .rst, .converter_enable, .go_set, .go_clear, .result_justify_sel,
        .pos_ref_sel, .input_channel_sel, .conv_clock_sel, .conv_complete_irq_en, .flag_clear,
        .sleep_active, .rc_osc_tick, .comparator_out, .mux_channel, .ref_pin_sel, .sample_closed,
        .dac_code, .analog_on, .go_busy, .conv_complete_flag, .conv_irq, .wake_req, .result_high,
        .result_low);
    analog_front afe (.clk, .mux_channel, .ref_pin_sel, .sample_closed, .dac_code, .analog_on,
        .comparator_out, .rc_osc_tick);

    always #5 clk = ~clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One-cycle software write pulse: {go, stop, flag clear}
    task automatic strobe(input logic [2:0] m);
        @(negedge clk) {go_set, go_clear, flag_clear} = m;
        @(negedge clk) {go_set, go_clear, flag_clear} = 3'b000;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (go_busy !== 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        cmp("busy_timeout", 0, {15'h0, n == 3000});
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_convert(input logic [3:0] c, input logic r, j, input logic [2:0] s);
        logic [9:0] v;
        v = {c, 6'h2b} ^ {10{r}};
        input_channel_sel = c;
        pos_ref_sel = r;
        result_justify_sel = j;
        conv_clock_sel = s;
        conv_complete_irq_en = s[2];
        cycles(20); // acquisition settle
        strobe(3'b001);
        cmp("sample_open", 1, sample_closed);
        strobe(3'b100);
        cmp("busy", 1, go_busy);
        cycles(1);
        cmp("sample_rc", s[1:0] == 2'b11, sample_closed);
        cycles(7);
        cmp("sample_shut", 0, sample_closed);
        wait_idle();
        cmp("flag", 1, conv_complete_flag);
        cmp("result", j ? {6'h00, v} : {v, 6'h00}, {result_high, result_low});
        cycles(1);
        cmp("irq", s[2], conv_irq);
        cmp("dac", v, dac_code);
        $display("test convert sel %b done", s);
    endtask
    task automatic t_abort;
        logic [15:0] keep;
        keep = {result_high, result_low};
        conv_clock_sel = 3'b101; // Slow enough for the minimum bit period
        strobe(3'b001);
        strobe(3'b100);
        cycles(60);
        strobe(3'b010);
        cmp("abort_busy", 0, go_busy);
        cmp("abort_result", keep, {result_high, result_low});
        cmp("abort_flag", 0, conv_complete_flag);
        strobe(3'b100);
        cmp("hold_busy", 0, go_busy);
        cycles(40);
        strobe(3'b100);
        cmp("restart_busy", 1, go_busy);
        wait_idle();
        conv_clock_sel = 3'b001;
        strobe(3'b100);
        cycles(20);
        sleep_active = 1;
        cycles(3);
        cmp("sleep_busy", 0, go_busy);
        cmp("sleep_analog", 0, analog_on);
        sleep_active = 0;
        cycles(10);
        // Dropping enable mid conversion also ends it
        strobe(3'b100);
        cycles(5);
        converter_enable = 0;
        cycles(2);
        cmp("disable_busy", 0, go_busy);
        cmp("disable_analog", 0, analog_on);
        converter_enable = 1;
        cycles(40); // hold passes, enable lands before any go
        $display("test abort done");
    endtask
    task automatic t_refuse;
        converter_enable = 0;
        strobe(3'b100);
        cycles(3);
        cmp("off_busy", 0, go_busy);
        cycles(50);
        cmp("flag_kept", 1, conv_complete_flag);
        strobe(3'b001);
        cmp("flag_cleared", 0, conv_complete_flag);
        converter_enable = 1;
        cycles(2); // enable lands before any go
        $display("test refuse done");
    endtask
    task automatic t_wake;
        conv_clock_sel = 3'b011;
        conv_complete_irq_en = 1;
        strobe(3'b100);
        sleep_active = 1;
        wait_idle();
        cycles(2);
        cmp("wake", 1, wake_req);
        cmp("wake_flag", 1, conv_complete_flag);
        sleep_active = 0;
        cycles(2);
        $display("test wake done");
    endtask
    task automatic t_reset;
        conv_clock_sel = 3'b110;
        strobe(3'b100);
        cycles(50);
        rst = 1;
        cycles(2);
        rst = 0;
        cycles(1);
        cmp("rst_busy", 0, go_busy);
        cmp("rst_state", 0, {conv_complete_flag, result_high, result_low[6:0]});
        $display("test reset done");
    endtask

    // Watchdog sized well past the longest expected run
    initial begin
        #500000;
        errors++;
        $display("mismatch watchdog expected finish seen timeout");
        stop_test();
    end

    initial begin
        cycles(6);
        rst = 0;
        converter_enable = 1;
        cycles(2); // enable first, go later
        for (int k = 0; k < 8; k++)
            t_convert(k[3:0], k[0], k[1], k[2:0]);
        t_refuse();
        t_abort();
        t_wake();
        t_reset();
        stop_test();
    end
endmodule // sar_adc_sequencer_bench
